// ---- src/twb_pkg.sv ----
// Purpose: Shared constants for the two-wire bus controller
// Assumes: AXI4-Lite register access, 25 MHz module clock
// Notes:   Byte address of each register is four times its index
package twb_pkg;
	// Register indices (byte address = index * 4)
	localparam logic [3:0] IDX_OWN  = 4'h0;
	localparam logic [3:0] IDX_DIV  = 4'h1;
	localparam logic [3:0] IDX_CR   = 4'h2;
	localparam logic [3:0] IDX_SR   = 4'h3;
	localparam logic [3:0] IDX_DAT  = 4'h4;
	localparam logic [3:0] IDX_EX   = 4'h5;
	localparam logic [3:0] IDX_IST  = 4'h6;
	localparam logic [3:0] IDX_ICLR = 4'h7;
	localparam logic [3:0] IDX_IEN  = 4'h8;
	// Reset value of every register
	localparam logic [7:0] RST_BYTE = 8'h00;
	// bus_control fields
	localparam int CR_EN   = 7;
	localparam int CR_IE   = 6;
	localparam int CR_MS   = 5;
	localparam int CR_TX   = 4;
	localparam int CR_TXAK = 3;
	localparam int CR_RSTA = 2;
	localparam int CR_SWAI = 0;
	localparam logic [7:0] CR_RMASK = 8'hf9;
	// bus_status fields written with one to clear
	localparam int SR_AL = 4;
	localparam int SR_IF = 1;
	// extended_address_control fields
	localparam int EX_GC = 7;
	localparam int EX_AT = 6;
	localparam logic [7:0] EX_MASK = 8'hc7;
	// Interrupt status bits
	localparam int INT_BYTE = 0;
	localparam int INT_ARB  = 1;
	localparam int INT_ADDR = 2;
	// Bus protocol values
	localparam logic [4:0] ADDR10_HDR = 5'h1e;
	localparam logic [7:0] GC_ADDR    = 8'h00;
	localparam logic [3:0] BIT_ACK    = 4'h8;
	localparam logic [3:0] BIT_PRE    = 4'hf;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Timing
	localparam int CLK_HZ      = 25_000_000;
	localparam int BUS_MAX_BPS = 100_000;
	localparam int STD_DIV     = CLK_HZ / BUS_MAX_BPS;
	localparam logic [12:0] HALF_MIN = 13'h00a;
	// Divider tables, one byte per entry
	localparam logic [63:0] SCL_TAP = 64'h0f0c0a0908070605;
	localparam logic [63:0] S2TAP   = 64'h7e3e1e0e06060404;

	// Half of the serial clock period in module clocks
	function automatic logic [12:0] twb_half(input logic [7:0] rs);
		logic [7:0]  tap;
		logic [7:0]  s2t;
		logic [12:0] b;
		tap = SCL_TAP[{rs[2:0], 3'h0} +: 8];
		s2t = S2TAP[{rs[5:3], 3'h0} +: 8];
		b = 13'(s2t) + (13'(tap - 8'h01) << rs[5:3]) + 13'h002;
		twb_half = (rs[7:6] == 2'h3) ? b : (b << rs[7:6]);
	endfunction : twb_half
endpackage : twb_pkg

// ---- src/twb_top.sv ----
// Purpose: Two-wire bus controller, master and slave, AXI4-Lite registers
// Assumes: Bus pins synchronous to i_clk; open-drain pads outside
// Notes:   Pins only ever pull low; slave role until master is selected
// Operation
// [RULE1] Own slave address in bits 7:1
// [RULE2] Address bit 0 always reads zero
// [RULE3] Slave operation unless master selected
// [RULE4] Own address never sent as master; the code sends whatever address software loads into the data register
// [RULE5] Up to 100 kbps, at most clock/20
// [RULE6] 256 software divider settings
// [RULE7] Arbitration loss interrupts, reverts to slave
// [RULE8] Interrupt when own address called
// [RULE9] Byte transfers, interrupt per byte
// [RULE10] Generate/detect start, stop, repeated start
// [RULE11] Selectable acknowledge, detect partner acknowledge
// [RULE12] Recognise general call address
// [RULE13] Ten-bit addressing via second control register
// [RULE14] Same in all modes; wait, stop
// [RULE15] Clock and data pins are bidirectional
// [RULE16] Top divider bits pick multiplier 1/2/4
// [RULE17] Period equals multiplier times twice tap sum
// [RULE18] Register access in module clock, zeros unimplemented
//
// The AXI4-Lite register port was decided locally.
`timescale 1ns/1ns
module twb_top (
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	// Low-power requests
	input  wire logic        i_wait,
	input  wire logic        i_stop,
	// AXI4-Lite write channels
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	output logic [1:0]       o_bresp,
	// AXI4-Lite read channels
	input  wire logic        i_arvalid,
	output logic             o_arready,
	input  wire logic [7:0]  i_araddr,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	// Serial clock pin
	input  wire logic        i_scl,
	output logic             o_scl_o,
	output logic             o_scl_oe,
	// Serial data pin
	input  wire logic        i_sda,
	output logic             o_sda_o,
	output logic             o_sda_oe,
	// Interrupt
	output logic             o_irq
);
	typedef enum logic [2:0] {IDLE, START, RUN, RS1, RS2, STOP1, STOP2} twb_st_e;

	typedef struct packed {
		twb_st_e     st;
		logic [6:0]  own;
		logic [7:0]  div;
		logic [7:0]  cr;
		logic [7:0]  ex;
		logic        tcf, iaas, ibb, ibal, srw, rxak;
		logic [7:0]  dat, sh;
		logic [2:0]  ist, ien;
		logic [12:0] cnt;
		logic        scl_lo, sda_lo, scl_q, sda_q, hold, aph, go_p, stop_p, rs_p;
		logic [3:0]  bitn;
		logic        awg, wg, awr, wr, bv, arr, rv, irq, wmap, wstb;
		logic [3:0]  widx;
		logic [7:0]  wd, rd;
		logic [1:0]  bresp, rresp;
	} twb_state_s;

	twb_state_s  s, n;
	logic [12:0] hp;
	logic        run, rise, fall, start_d, stop_d, txr, match, gc, lost, tick;

	// Next-state logic: bus slave first, then bus engine, so hardware sets win
	always_comb begin
		n = s;
		hp = twb_pkg::twb_half(s.div); // [RULE6] [RULE16] [RULE17]
		run = s.cr[twb_pkg::CR_EN] & ~i_stop & ~(i_wait & s.cr[twb_pkg::CR_SWAI]); // [RULE14]
		rise = i_scl & ~s.scl_q;
		fall = ~i_scl & s.scl_q;
		start_d = s.scl_q & i_scl & s.sda_q & ~i_sda; // [RULE10]
		stop_d = s.scl_q & i_scl & ~s.sda_q & i_sda; // [RULE10]
		txr = s.cr[twb_pkg::CR_MS] ? (s.aph | s.cr[twb_pkg::CR_TX]) : (s.iaas & s.srw);
		gc = s.ex[twb_pkg::EX_GC] & (s.sh == twb_pkg::GC_ADDR); // [RULE12]
		match = gc | (s.ex[twb_pkg::EX_AT] ? // [RULE13]
			(s.sh[7:3] == twb_pkg::ADDR10_HDR && s.sh[2:1] == s.ex[1:0]) :
			(s.sh[7:1] == s.own)); // [RULE1]
		lost = run & rise & s.cr[twb_pkg::CR_MS] & (s.st == RUN) & (s.bitn < twb_pkg::BIT_ACK)
			& txr & ~s.sda_lo & ~i_sda;
		tick = (s.cnt == 13'h0000);
		n.scl_q = i_scl;
		n.sda_q = i_sda;

		// Write channels: address and data taken in either order
		if (i_awvalid && s.awr) begin
			n.awg = 1'b1;
			n.widx = i_awaddr[5:2];
			n.wmap = (i_awaddr[7:6] == 2'h0) && (i_awaddr[5:2] <= twb_pkg::IDX_IEN);
		end
		if (i_wvalid && s.wr) begin
			n.wg = 1'b1;
			n.wd = i_wdata[7:0];
			n.wstb = i_wstrb[0];
		end
		if (s.bv && i_bready)
			n.bv = 1'b0;
		if (s.awg && s.wg && !s.bv) begin // [RULE18]
			n.awg = 1'b0;
			n.wg = 1'b0;
			n.bv = 1'b1;
			n.bresp = s.wmap ? twb_pkg::RESP_OKAY : twb_pkg::RESP_SLVERR;
			if (s.wmap && s.wstb) begin
				case (s.widx)
					twb_pkg::IDX_OWN: n.own = s.wd[7:1]; // [RULE1]
					twb_pkg::IDX_DIV: n.div = s.wd; // [RULE6]
					twb_pkg::IDX_CR: begin
						n.cr = s.wd & twb_pkg::CR_RMASK;
						if (s.wd[twb_pkg::CR_MS] && !s.cr[twb_pkg::CR_MS]) begin
							// Start refused while another party holds the bus
							if (s.ibb) begin
								n.cr[twb_pkg::CR_MS] = 1'b0;
								n.ibal = 1'b1;
								n.ist[twb_pkg::INT_ARB] = 1'b1;
							end else
								n.go_p = 1'b1; // [RULE10]
						end
						if (!s.wd[twb_pkg::CR_MS] && s.cr[twb_pkg::CR_MS])
							n.stop_p = 1'b1; // [RULE10]
						if (s.wd[twb_pkg::CR_MS] && s.cr[twb_pkg::CR_MS] && s.wd[twb_pkg::CR_RSTA])
							n.rs_p = 1'b1; // [RULE10]
					end
					twb_pkg::IDX_SR: begin
						if (s.wd[twb_pkg::SR_AL])
							n.ibal = 1'b0;
						if (s.wd[twb_pkg::SR_IF])
							n.ist = 3'h0;
					end
					twb_pkg::IDX_DAT: begin
						n.dat = s.wd;
						// Outgoing address is whatever software loads here [RULE4]
						if (s.hold && txr) begin
							n.sh = s.wd;
							n.hold = 1'b0;
							n.tcf = 1'b0;
							n.sda_lo = ~s.wd[7];
						end
					end
					twb_pkg::IDX_EX: n.ex = s.wd & twb_pkg::EX_MASK; // [RULE13]
					twb_pkg::IDX_ICLR: n.ist = s.ist & ~s.wd[2:0];
					twb_pkg::IDX_IEN: n.ien = s.wd[2:0];
					default: ;
				endcase
			end
		end

		// Read channel: answer one cycle after the address is taken
		if (s.rv && i_rready)
			n.rv = 1'b0;
		if (i_arvalid && s.arr) begin
			n.rv = 1'b1;
			n.rd = twb_pkg::RST_BYTE;
			n.rresp = twb_pkg::RESP_OKAY;
			if (i_araddr[7:6] != 2'h0)
				n.rresp = twb_pkg::RESP_SLVERR;
			else begin
				case (i_araddr[5:2])
					twb_pkg::IDX_OWN: n.rd = {s.own, 1'b0}; // [RULE2]
					twb_pkg::IDX_DIV: n.rd = s.div;
					twb_pkg::IDX_CR: n.rd = s.cr & twb_pkg::CR_RMASK; // [RULE18]
					twb_pkg::IDX_SR: n.rd = {s.tcf, s.iaas, s.ibb, s.ibal, 1'b0, s.srw, |s.ist, s.rxak};
					twb_pkg::IDX_DAT: begin
						n.rd = s.dat;
						// Reading a received byte lets the next one in
						if (s.hold && !txr) begin
							n.hold = 1'b0;
							n.tcf = 1'b0;
						end
					end
					twb_pkg::IDX_EX: n.rd = s.ex;
					twb_pkg::IDX_IST: n.rd = {5'h00, s.ist};
					twb_pkg::IDX_ICLR: n.rd = twb_pkg::RST_BYTE;
					twb_pkg::IDX_IEN: n.rd = {5'h00, s.ien};
					default: n.rresp = twb_pkg::RESP_SLVERR;
				endcase
			end
		end

		// Bus monitor, shared by master and slave roles
		if (run) begin
			if (start_d) begin
				n.ibb = 1'b1;
				n.aph = 1'b1;
				n.bitn = twb_pkg::BIT_PRE;
				n.iaas = 1'b0;
			end
			if (stop_d) begin
				n.ibb = 1'b0;
				n.aph = 1'b0;
				n.iaas = 1'b0;
				n.hold = 1'b0;
			end
			if (rise) begin
				if (s.bitn < twb_pkg::BIT_ACK)
					n.sh = {s.sh[6:0], i_sda};
				else if (s.bitn == twb_pkg::BIT_ACK)
					n.rxak = i_sda; // [RULE11]
			end
			if (lost) begin // [RULE7]
				n.cr[twb_pkg::CR_MS] = 1'b0;
				n.ibal = 1'b1;
				n.ist[twb_pkg::INT_ARB] = 1'b1;
				n.stop_p = 1'b0;
				n.rs_p = 1'b0;
			end
			if (fall) begin
				if (s.bitn == twb_pkg::BIT_PRE) begin
					n.bitn = 4'h0;
					n.sda_lo = 1'b0;
				end else if (s.bitn == 4'h7) begin
					n.bitn = twb_pkg::BIT_ACK;
					n.sda_lo = 1'b0;
					if (s.aph && !n.cr[twb_pkg::CR_MS] && match) begin // [RULE3] [RULE8]
						n.iaas = 1'b1;
						n.srw = s.sh[0] & ~gc;
						n.ist[twb_pkg::INT_ADDR] = 1'b1;
						n.sda_lo = 1'b1;
					end else if (!txr && !s.aph && (s.cr[twb_pkg::CR_MS] | s.iaas))
						n.sda_lo = ~s.cr[twb_pkg::CR_TXAK]; // [RULE11]
				end else if (s.bitn == twb_pkg::BIT_ACK) begin
					n.bitn = 4'h0;
					n.sda_lo = 1'b0;
					n.aph = 1'b0;
					if (s.cr[twb_pkg::CR_MS] | s.iaas) begin // [RULE9]
						n.tcf = 1'b1;
						n.hold = 1'b1;
						n.ist[twb_pkg::INT_BYTE] = 1'b1;
						if (!txr)
							n.dat = s.sh;
					end
				end else if (s.bitn < 4'h7) begin
					n.bitn = s.bitn + 4'h1;
					n.sda_lo = txr & ~s.sh[7];
				end
			end

			// Half-period counter; idle reload gives a full first half
			n.cnt = (tick || s.st == IDLE) ? (hp - 13'h0001) : (s.cnt - 13'h0001); // [RULE5]

			// Master sequencer
			case (s.st)
				IDLE: begin
					if (s.go_p) begin
						n.go_p = 1'b0;
						if (s.ibb) begin
							n.cr[twb_pkg::CR_MS] = 1'b0;
							n.ibal = 1'b1;
							n.ist[twb_pkg::INT_ARB] = 1'b1;
						end else begin
							n.sda_lo = 1'b1; // [RULE10]
							n.st = START;
						end
					end
				end
				START: begin
					if (tick) begin
						n.scl_lo = 1'b1;
						n.hold = 1'b1;
						n.st = RUN;
					end
				end
				RUN: begin
					if (lost) begin // [RULE7]
						n.st = IDLE;
						n.scl_lo = 1'b0;
						n.sda_lo = 1'b0;
					end else if (s.scl_lo && s.stop_p) begin
						n.stop_p = 1'b0;
						n.hold = 1'b0;
						n.sda_lo = 1'b1;
						n.st = STOP1;
					end else if (s.hold && s.rs_p) begin
						n.rs_p = 1'b0;
						n.hold = 1'b0;
						n.sda_lo = 1'b0;
						n.st = RS1;
					end else if (!s.hold && tick) begin
						// A slave stretching the clock delays the next low phase
						if (s.scl_lo)
							n.scl_lo = 1'b0;
						else if (i_scl)
							n.scl_lo = 1'b1;
					end
				end
				RS1: begin
					if (tick) begin
						n.scl_lo = 1'b0;
						n.st = RS2;
					end
				end
				RS2: begin
					if (tick && i_scl) begin
						n.sda_lo = 1'b1; // [RULE10]
						n.st = START;
					end
				end
				STOP1: begin
					if (tick) begin
						n.scl_lo = 1'b0;
						n.st = STOP2;
					end
				end
				STOP2: begin
					if (tick && i_scl) begin
						n.sda_lo = 1'b0; // [RULE10]
						n.st = IDLE;
					end
				end
				default: n.st = IDLE;
			endcase

			// Addressed slave stretches the clock until serviced
			if (n.st == IDLE && !n.cr[twb_pkg::CR_MS])
				n.scl_lo = n.hold & n.iaas;
		end

		// Disabled: let go of both lines and forget the transfer
		if (!s.cr[twb_pkg::CR_EN]) begin
			n.st = IDLE;
			n.scl_lo = 1'b0;
			n.sda_lo = 1'b0;
			n.hold = 1'b0;
			n.go_p = 1'b0;
			n.stop_p = 1'b0;
			n.rs_p = 1'b0;
			n.ibb = 1'b0;
			n.iaas = 1'b0;
		end

		n.awr = !n.awg && !n.bv;
		n.wr = !n.wg && !n.bv;
		n.arr = !n.rv;
		n.irq = n.cr[twb_pkg::CR_IE] & |(n.ist & n.ien);
	end

	// State register
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n)
			s <= '0;
		else
			s <= n;
	end

	// Outputs; pins only ever pull low [RULE15]
	assign o_awready = s.awr;
	assign o_wready  = s.wr;
	assign o_bvalid  = s.bv;
	assign o_bresp   = s.bresp;
	assign o_arready = s.arr;
	assign o_rvalid  = s.rv;
	assign o_rdata   = {24'h000000, s.rd};
	assign o_rresp   = s.rresp;
	assign o_scl_o   = 1'b0;
	assign o_scl_oe  = s.scl_lo;
	assign o_sda_o   = 1'b0;
	assign o_sda_oe  = s.sda_lo;
	assign o_irq     = s.irq;

	// Checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	property p_own_read;
		(i_arvalid && s.arr && i_araddr == 8'h00) |=> (o_rvalid && o_rdata[7:0] == {$past(s.own), 1'b0});
	endproperty
	a_own_read: assert property (p_own_read) else $error("own address read wrong"); // [RULE2]

	property p_slave_addr;
		$rose(s.iaas) |-> (!s.cr[twb_pkg::CR_MS] && s.ist[twb_pkg::INT_ADDR] && o_sda_oe);
	endproperty
	a_slave_addr: assert property (p_slave_addr) else $error("address match flags wrong"); // [RULE8]

	property p_arb;
		lost |=> (!s.cr[twb_pkg::CR_MS] && s.ibal && s.st == IDLE && !o_scl_oe);
	endproperty
	a_arb: assert property (p_arb) else $error("arbitration loss not handled"); // [RULE7]

	property p_byte;
		(run && fall && s.bitn == twb_pkg::BIT_ACK && s.iaas && !s.cr[twb_pkg::CR_MS])
			|=> (s.tcf && s.ist[twb_pkg::INT_BYTE] && o_scl_oe);
	endproperty
	a_byte: assert property (p_byte) else $error("slave byte not held"); // [RULE9]

	// Start: data low first, clock kept high for one half period from a fresh count
	property p_start;
		(run && s.st == IDLE && s.go_p && !s.ibb)
			|=> (o_sda_oe && !o_scl_oe && s.st == START && s.cnt < hp);
	endproperty
	a_start: assert property (p_start) else $error("start sequence wrong"); // [RULE10]

	// End of the start half period pulls the clock low with data still low
	property p_start_low;
		(run && s.st == START && tick) |=> (o_scl_oe && o_sda_oe && s.st == RUN);
	endproperty
	a_start_low: assert property (p_start_low) else $error("start clock low missing"); // [RULE10]

	property p_div;
		hp >= twb_pkg::HALF_MIN;
	endproperty
	a_div: assert property (p_div) else $error("bit rate above clock/20"); // [RULE5]

	property p_mul;
		(s.div[7:6] == 2'h2) |-> (hp == (twb_pkg::twb_half({2'h0, s.div[5:0]}) << 2));
	endproperty
	a_mul: assert property (p_mul) else $error("multiplier wrong"); // [RULE16]

	property p_ack;
		(run && fall && s.bitn == 4'h7 && s.cr[twb_pkg::CR_MS] && !txr && !s.aph && s.st == RUN)
			|=> (o_sda_oe == !$past(s.cr[twb_pkg::CR_TXAK]));
	endproperty
	a_ack: assert property (p_ack) else $error("acknowledge level wrong"); // [RULE11]

	property p_gc;
		(run && fall && s.bitn == 4'h7 && s.aph && !s.cr[twb_pkg::CR_MS] && gc) |=> (s.iaas && !s.srw);
	endproperty
	a_gc: assert property (p_gc) else $error("general call missed"); // [RULE12]

	property p_wresp;
		(s.awg && s.wg && !s.bv) |=> o_bvalid ##0 (o_bresp == ($past(s.wmap) ? 2'h0 : 2'h2));
	endproperty
	a_wresp: assert property (p_wresp) else $error("write response wrong"); // [RULE18]

	c_lost: cover property (lost);
	c_addr: cover property ($rose(s.iaas));
	c_rstart: cover property (s.st == RS2 ##1 s.st == START);
	c_stop: cover property (s.st == STOP2 ##1 s.st == IDLE);
endmodule : twb_top

// ---- test/twb_bus_model.sv ----
// Purpose: Behavioural party on the shared two-wire bus, master and slave
// Assumes: Lines float high when released; oe high pulls a line low
// Notes:   Master tasks are called from the bench; slave side acks bytes
`timescale 1ns/1ns
module twb_bus_model (
	// Clock
	input  wire logic i_clk,
	// Wire levels
	input  wire logic i_scl,
	input  wire logic i_sda,
	// Pull-down enables
	output logic      o_scl_oe,
	output logic      o_sda_oe
);
	int         half_cyc = 50;
	int         nbits    = 0;
	int         starts   = 0;
	int         stops    = 0;
	logic [7:0] rx_byte  = 8'h00;
	logic       mst      = 1'b0;
	logic       m_scl    = 1'b0;
	logic       m_sda    = 1'b0;
	logic       ack_oe   = 1'b0;
	logic       scl_q    = 1'b1;
	logic       sda_q    = 1'b1;

	// Open drain only: a released line goes to the pull-up level
	assign o_scl_oe = m_scl;
	assign o_sda_oe = m_sda | ack_oe;

	// Start and stop detection, bit capture, ack as slave
	always @(posedge i_clk) begin
		if (scl_q && i_scl && sda_q && !i_sda) begin
			starts++;
			nbits = 0;
		end
		if (scl_q && i_scl && !sda_q && i_sda)
			stops++;
		if (!scl_q && i_scl && nbits < 9) begin
			if (nbits < 8)
				rx_byte = {rx_byte[6:0], i_sda};
			nbits++;
		end
		if (scl_q && !i_scl) begin
			ack_oe <= (nbits == 8) && !mst;
			if (nbits == 9)
				nbits = 0;
		end
		scl_q <= i_scl;
		sda_q <= i_sda;
	end

	task automatic wait_half;
		repeat (half_cyc) @(posedge i_clk);
	endtask : wait_half

	// One bit; a slave stretching the clock low simply delays it
	task automatic m_bit(input logic b, output logic s);
		m_sda <= !b;
		wait_half();
		m_scl <= 1'b0;
		do @(posedge i_clk); while (!i_scl);
		wait_half();
		s = i_sda;
		m_scl <= 1'b1;
	endtask : m_bit

	task automatic m_start;
		mst = 1'b1;
		@(posedge i_clk);
		m_sda <= 1'b1;
		wait_half();
		m_scl <= 1'b1;
	endtask : m_start

	// Most significant bit first, ninth bit returns the acknowledge
	task automatic m_byte(input logic [7:0] b, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--)
			m_bit(b[i], s);
		m_bit(1'b1, nack);
	endtask : m_byte

	task automatic m_stop;
		m_sda <= 1'b1;
		wait_half();
		m_scl <= 1'b0;
		do @(posedge i_clk); while (!i_scl);
		wait_half();
		m_sda <= 1'b0;
		wait_half();
		mst = 1'b0;
	endtask : m_stop
endmodule : twb_bus_model

// ---- test/twb_top_tb.sv ----
// Purpose: Self-checking bench for the two-wire bus controller
// Assumes: Register bus master per AXI4-Lite, bus model on the far side
// Notes:   Each scenario is one task that checks its own results
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
	$display("[FAIL] t=%0t got %0h exp %0h", $time, g, e); end end
module twb_top_tb;
	logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        awready, wready, bvalid, arready, rvalid, irq, scl_d;
	logic        stp, scl_o, sda_o;
	logic [1:0]  bresp, rresp;
	logic        scl_oe, sda_oe, m_scl_oe, m_sda_oe;
	wire         scl_w = !(scl_oe | m_scl_oe);
	wire         sda_w = !(sda_oe | m_sda_oe);
	int          err_count = 0;
	int          num_checks = 0;
	int          cnt = 0;
	int          last_per = 0;

	twb_top u_twb_top (.i_clk(clk), .i_reset_n(rst_n), .i_wait(1'b0), .i_stop(stp),
		.i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
		.o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready),
		.o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_scl(scl_w),
		.o_scl_o(scl_o), .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .o_irq(irq));
	twb_bus_model u_twb_bus_model (.i_clk(clk), .i_scl(scl_w), .i_sda(sda_w), .o_scl_oe(m_scl_oe),
		.o_sda_oe(m_sda_oe));

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// Serial clock period between falling edges, in module clocks
	always @(posedge clk) begin
		scl_d <= scl_w;
		if (scl_d && !scl_w) begin
			last_per <= cnt;
			cnt <= 1;
		end else
			cnt <= cnt + 1;
	end

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
		@(posedge clk);
		{awvalid, wvalid, bready} <= 3'h7;
		awaddr <= {2'h0, idx, 2'h0};
		wdata <= {24'h000000, d};
		do begin
			@(posedge clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		`CHK(bresp, er)
	endtask : wr

	task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
		@(posedge clk);
		{arvalid, rready} <= 2'h3;
		araddr <= {2'h0, idx, 2'h0};
		do begin
			@(posedge clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	task automatic chk_rd(input logic [3:0] idx, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(idx, d, r);
		`CHK(d, e)
		`CHK(r, twb_pkg::RESP_OKAY)
	endtask : chk_rd

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 8000) begin
			@(posedge clk);
			n++;
		end
		`CHK(irq, 1'b1)
	endtask : wait_irq

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		for (int i = 0; i < 9; i++)
			chk_rd(4'(i), {24'h000000, twb_pkg::RST_BYTE});
		`CHK({scl_o, sda_o}, 2'h0)
		wr(twb_pkg::IDX_OWN, 8'hff, twb_pkg::RESP_OKAY);
		chk_rd(twb_pkg::IDX_OWN, 32'h000000fe);
		wr(twb_pkg::IDX_EX, 8'hff, twb_pkg::RESP_OKAY);
		chk_rd(twb_pkg::IDX_EX, 32'h000000c7);
		wr(twb_pkg::IDX_EX, 8'h00, twb_pkg::RESP_OKAY);
		for (int i = 0; i < 256; i++) begin
			wr(twb_pkg::IDX_DIV, 8'(i), twb_pkg::RESP_OKAY);
			chk_rd(twb_pkg::IDX_DIV, 32'(i));
		end
		wr(4'h9, 8'h12, twb_pkg::RESP_SLVERR);
		rd(4'h9, d, r);
		`CHK(r, twb_pkg::RESP_SLVERR)
		`CHK(d, 32'h00000000)
		$display("test regs done");
	endtask : t_regs

	// Master transmit at three divider settings; period is twice the half period
	task automatic t_master;
		logic [7:0] dv [3] = '{8'h00, 8'h01, 8'h41};
		int         pv [3] = '{20, 22, 44};
		int         n;
		wr(twb_pkg::IDX_OWN, 8'h54, twb_pkg::RESP_OKAY);
		wr(twb_pkg::IDX_IEN, 8'h07, twb_pkg::RESP_OKAY);
		for (int i = 0; i < 3; i++) begin
			wr(twb_pkg::IDX_DIV, dv[i], twb_pkg::RESP_OKAY);
			wr(twb_pkg::IDX_CR, 8'hd0, twb_pkg::RESP_OKAY);
			wr(twb_pkg::IDX_CR, 8'hf0, twb_pkg::RESP_OKAY);
			// Data written before the start pulls the clock low would not be sent
			n = 0;
			while (scl_w && n < 200) begin
				@(posedge clk);
				n++;
			end
			`CHK(scl_w, 1'b0)
			wr(twb_pkg::IDX_DAT, 8'ha0, twb_pkg::RESP_OKAY);
			wait_irq();
			`CHK(u_twb_bus_model.rx_byte, 8'ha0)
			`CHK(last_per, pv[i])
			chk_rd(twb_pkg::IDX_SR, 32'h000000a2);
			chk_rd(twb_pkg::IDX_IST, 32'h00000001);
			wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
			wr(twb_pkg::IDX_CR, 8'hd0, twb_pkg::RESP_OKAY);
			n = 0;
			while (u_twb_bus_model.stops < i + 1 && n < 3000) begin
				@(posedge clk);
				n++;
			end
			`CHK(u_twb_bus_model.starts, i + 1)
			`CHK(u_twb_bus_model.stops, i + 1)
			`CHK(irq, 1'b0)
		end
		$display("test master done");
	endtask : t_master

	// Far master calls an address; only a match stretches and interrupts
	task automatic t_call(input logic [7:0] a, input logic exp_n);
		logic        n;
		logic [31:0] d;
		logic [1:0]  r;
		wr(twb_pkg::IDX_CR, 8'hc0, twb_pkg::RESP_OKAY);
		fork
			begin
				u_twb_bus_model.m_start();
				u_twb_bus_model.m_byte(a, n);
				u_twb_bus_model.m_stop();
			end
			if (!exp_n) begin
				wait_irq();
				rd(twb_pkg::IDX_IST, d, r);
				`CHK(d[twb_pkg::INT_ADDR], 1'b1)
				wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
				wait_irq();
				wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
				rd(twb_pkg::IDX_DAT, d, r);
				`CHK(d[7:0], twb_pkg::GC_ADDR)
			end
		join
		`CHK(n, exp_n)
		`CHK(irq, 1'b0)
		$display("test call done");
	endtask : t_call

	// Slave receive with software-chosen acknowledge
	task automatic t_slave;
		logic        n1, n2, n3;
		fork
			begin
				u_twb_bus_model.m_start();
				u_twb_bus_model.m_byte(8'h54, n1);
				u_twb_bus_model.m_byte(8'h3c, n2);
				u_twb_bus_model.m_byte(8'h99, n3);
				u_twb_bus_model.m_stop();
			end
			begin
				// Address match flags on the eighth fall, the byte on the ninth
				wait_irq();
				wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
				wait_irq();
				wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
				chk_rd(twb_pkg::IDX_DAT, 32'h00000054);
				wait_irq();
				wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
				wr(twb_pkg::IDX_CR, 8'hc8, twb_pkg::RESP_OKAY);
				chk_rd(twb_pkg::IDX_DAT, 32'h0000003c);
				wait_irq();
				wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
				chk_rd(twb_pkg::IDX_DAT, 32'h00000099);
			end
		join
		`CHK(n1, 1'b0)
		`CHK(n2, 1'b0)
		`CHK(n3, 1'b1)
		$display("test slave done");
	endtask : t_slave

	// Master request while the bus is busy loses, stays slave, interrupts
	task automatic t_arb;
		wr(twb_pkg::IDX_CR, 8'hc0, twb_pkg::RESP_OKAY);
		u_twb_bus_model.m_start();
		wr(twb_pkg::IDX_CR, 8'he0, twb_pkg::RESP_OKAY);
		chk_rd(twb_pkg::IDX_CR, 32'h000000c0);
		chk_rd(twb_pkg::IDX_IST, 32'h00000002);
		`CHK(irq, 1'b1)
		wr(twb_pkg::IDX_IEN, 8'h00, twb_pkg::RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		wr(twb_pkg::IDX_IEN, 8'h07, twb_pkg::RESP_OKAY);
		wr(twb_pkg::IDX_ICLR, 8'h07, twb_pkg::RESP_OKAY);
		repeat (2) @(posedge clk);
		`CHK(irq, 1'b0)
		chk_rd(twb_pkg::IDX_IST, 32'h00000000);
		u_twb_bus_model.m_stop();
		$display("test arb done");
	endtask : t_arb

	// Stop mode freezes the bus engine; a pending start waits until it ends
	task automatic t_low;
		wr(twb_pkg::IDX_CR, 8'hc0, twb_pkg::RESP_OKAY);
		stp <= 1'b1;
		wr(twb_pkg::IDX_CR, 8'he0, twb_pkg::RESP_OKAY);
		repeat (30) @(posedge clk);
		`CHK(sda_oe, 1'b0)
		stp <= 1'b0;
		repeat (3) @(posedge clk);
		`CHK(sda_oe, 1'b1)
		wr(twb_pkg::IDX_CR, 8'hc0, twb_pkg::RESP_OKAY);
		repeat (200) @(posedge clk);
		`CHK({scl_oe, sda_oe}, 2'h0)
		$display("test low power done");
	endtask : t_low

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		{rst_n, stp, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{awaddr, araddr, wdata, wstrb} = {8'h00, 8'h00, 32'h00000000, 4'h1};
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_regs();
		t_master();
		t_call(8'h66, 1'b1);
		wr(twb_pkg::IDX_EX, 8'h80, twb_pkg::RESP_OKAY);
		t_call(twb_pkg::GC_ADDR, 1'b0);
		t_slave();
		t_arb();
		t_low();
		wrap_up();
	end

	// Watchdog, well beyond the expected run length
	initial begin
		repeat (80000) @(posedge clk);
		err_count++;
		$display("[FAIL] t=%0t watchdog expired", $time);
		wrap_up();
	end
endmodule : twb_top_tb
